// ### rtl/can_diag_defs.vh
// Purpose: constants for the CAN diagnostic flag block
// Assumes: 25 MHz core clock, word-aligned Avalon-MM registers
// Notes: byte addresses; flag bit positions shared by all files
`ifndef CAN_DIAG_DEFS_VH
`define CAN_DIAG_DEFS_VH

`define CLK_PERIOD_NS 40
`define DOM_TIMEOUT_NS 2000
`define DOM_TIMEOUT_CYC (`DOM_TIMEOUT_NS / `CLK_PERIOD_NS)
`define DOM_CNT_W 16

`define NUM_FLAGS 14
`define NUM_RT 3
`define NUM_SYNC 17

`define FLG_OVERTEMP 0
`define FLG_RX_LOW 1
`define FLG_RX_HIGH 2
`define FLG_TX_DOM 3
`define FLG_BUS_CLAMP 4
`define FLG_OVERCUR 5
`define FLG_FAIL_PEND 6
`define FLG_FAIL_IDENT 7
`define FLG_CANL_BAT 8
`define FLG_CANL_VDD 9
`define FLG_CANL_GND 10
`define FLG_CANH_BAT 11
`define FLG_CANH_VDD 12
`define FLG_CANH_GND 13

`define RT_LSB 16

`define ADDR_FLAGS 4'h0
`define ADDR_ISTAT 4'h4
`define ADDR_IMASK 4'h8
`define ADDR_CMD 4'hc

`define CMD_FLAG_READ 32'h00002180
`define IMASK_RESET 14'h0000
`endif

// ### rtl/flag_sync.v
// Purpose: two-stage synchroniser for asynchronous detector levels
// Assumes: inputs are slow levels, no bus coherence needed
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else if (ce_i) begin
          meta_r[g] <= d_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate
  assign q_o = sync_r;
endmodule
`default_nettype wire

// ### rtl/flag_latch.v
// Purpose: bank of latched fault flags
// Assumes: clr_i marks only bits already reported to the host
// Notes: a present fault always wins over a clear
`timescale 1ns/1ps
`default_nettype none
module flag_latch #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] cond_i,
  input wire [W-1:0] clr_i,
  output wire [W-1:0] flag_o,
  output wire [W-1:0] rise_o
);
  reg [W-1:0] flag_r;
  wire [W-1:0] flag_nxt;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      assign flag_nxt[g] = cond_i[g] | (flag_r[g] & ~clr_i[g]);
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          flag_r[g] <= 1'b0;
        end else if (ce_i) begin
          flag_r[g] <= flag_nxt[g];
        end
      end
    end
  endgenerate
  assign flag_o = flag_r;
  assign rise_o = flag_nxt & ~flag_r;
endmodule
`default_nettype wire

// ### rtl/can_diag_flags.v
// Purpose: latched CAN transceiver diagnostic flags, Avalon-MM slave
// Assumes: detector inputs are asynchronous levels, high = fault
// Notes: reading the flag register is the flag-read operation
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "can_diag_defs.vh"

// How it works
// - overtemperature flag sets on sensor over limit; clears when cool and read
// - receive-low flag latches on short to ground; clears after recovery and read
// - receive-high flag latches on recessive stuck; clears after recovery and read
// - transmit-dominant flag latches on short low; clears after removal and read
// - bus clamp flag latches when dominant beyond timeout; clears after recovery, read
// - overcurrent flag sets above limit; clears when below and read
// - bus-failure-pending flag sets at pre-detection; clears after recovery and read
// - bus-failure-identified flag sets on classification; clears after recovery, read
// - three low-wire short flags: battery, supply, ground; recovery plus read clears
// - three high-wire short flags: battery, supply, ground; recovery plus read clears
// - flag read clears gone faults; real-time state bits are never touched
module can_diag_flags (
  input wire MCLK_I,
  input wire RESET_I,
  input wire CE_I,
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output wire [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  output wire IRQ_O,
  input wire OVERTEMP_I,
  input wire RX_LOW_I,
  input wire RX_HIGH_I,
  input wire TX_DOM_I,
  input wire BUS_DOM_I,
  input wire OVERCURRENT_I,
  input wire BUS_FAIL_PENDING_I,
  input wire BUS_FAIL_IDENT_I,
  input wire CANL_BAT_I,
  input wire CANL_VDD_I,
  input wire CANL_GND_I,
  input wire CANH_BAT_I,
  input wire CANH_VDD_I,
  input wire CANH_GND_I,
  input wire DRV_EN_I,
  input wire RCV_EN_I,
  input wire WAKE_RCV_EN_I
);
  localparam integer DOM_CYC_I = `DOM_TIMEOUT_CYC;
  // counter is wide enough for the timeout; cut on purpose
  localparam [`DOM_CNT_W-1:0] DOM_CYC = DOM_CYC_I[`DOM_CNT_W-1:0];

  function is_reg;
    input [3:0] addr;
    input [3:0] which;
    begin
      is_reg = (addr[3:2] == which[3:2]);
    end
  endfunction

  // real-time bits ride along unlatched
  function [31:0] flags_word;
    input [`NUM_FLAGS-1:0] f;
    input [`NUM_RT-1:0] s;
    begin
      flags_word = 32'h00000000;
      flags_word[`NUM_FLAGS-1:0] = f;
      flags_word[`RT_LSB+`NUM_RT-1:`RT_LSB] = s;
    end
  endfunction

  wire [`NUM_SYNC-1:0] raw;
  wire [`NUM_SYNC-1:0] syn;
  wire [`NUM_FLAGS-1:0] cond;
  wire [`NUM_FLAGS-1:0] flag;
  wire [`NUM_FLAGS-1:0] rise;
  wire [`NUM_FLAGS-1:0] flag_clr;
  wire [`NUM_RT-1:0] rt_state;
  wire bus_dom_s;

  reg [`DOM_CNT_W-1:0] dom_cnt_r;
  reg [`DOM_CNT_W-1:0] dom_cnt_nxt;
  reg clamp_r;
  reg clamp_nxt;

  reg wait_r;
  reg wait_nxt;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  reg [`NUM_FLAGS-1:0] snap_r;
  reg [`NUM_FLAGS-1:0] snap_nxt;
  reg [`NUM_FLAGS-1:0] istat_r;
  reg [`NUM_FLAGS-1:0] istat_nxt;
  reg [`NUM_FLAGS-1:0] imask_r;
  reg [`NUM_FLAGS-1:0] imask_nxt;
  reg [`NUM_FLAGS-1:0] iclr;
  reg irq_r;
  reg irq_nxt;
  reg fclr_go;

  wire req;
  wire done;

  assign raw = {
    WAKE_RCV_EN_I, RCV_EN_I, DRV_EN_I,
    CANH_GND_I, CANH_VDD_I, CANH_BAT_I,
    CANL_GND_I, CANL_VDD_I, CANL_BAT_I,
    BUS_FAIL_IDENT_I, BUS_FAIL_PENDING_I, OVERCURRENT_I,
    BUS_DOM_I, TX_DOM_I, RX_HIGH_I, RX_LOW_I, OVERTEMP_I
  };

  // detector levels come from the analogue side
  flag_sync #(
    .W(`NUM_SYNC)
  ) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .d_i(raw),
    .q_o(syn)
  );

  assign bus_dom_s = syn[`FLG_BUS_CLAMP];
  assign rt_state = syn[`NUM_SYNC-1:`NUM_FLAGS];

  always @* begin
    dom_cnt_nxt = dom_cnt_r;
    clamp_nxt = clamp_r;
    if (!bus_dom_s) begin
      dom_cnt_nxt = {`DOM_CNT_W{1'b0}};
      clamp_nxt = 1'b0;
    end else if (dom_cnt_r >= DOM_CYC) begin
      clamp_nxt = 1'b1;
    end else begin
      dom_cnt_nxt = dom_cnt_r + {{(`DOM_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dom_cnt_r <= {`DOM_CNT_W{1'b0}};
    end else if (CE_I) begin
      dom_cnt_r <= dom_cnt_nxt;
    end
  end

  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      clamp_r <= 1'b0;
    end else if (CE_I) begin
      clamp_r <= clamp_nxt;
    end
  end

  assign cond = {
    syn[`FLG_CANH_GND:`FLG_CANL_BAT],
    syn[`FLG_FAIL_IDENT],
    syn[`FLG_FAIL_PEND],
    syn[`FLG_OVERCUR],
    clamp_r,
    syn[`FLG_TX_DOM:`FLG_OVERTEMP]
  };

  // clear only what the host has seen
  assign flag_clr = fclr_go ? snap_r : {`NUM_FLAGS{1'b0}};

  flag_latch #(
    .W(`NUM_FLAGS)
  ) u_latch (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .cond_i(cond),
    .clr_i(flag_clr),
    .flag_o(flag),
    .rise_o(rise)
  );

  assign req = AVS_READ_I | AVS_WRITE_I;
  assign done = req & ~wait_r;

  // bus slave: answer one cycle after the request is seen
  always @* begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    snap_nxt = snap_r;
    fclr_go = 1'b0;
    iclr = {`NUM_FLAGS{1'b0}};
    imask_nxt = imask_r;
    if (req && wait_r) begin
      wait_nxt = 1'b0;
      snap_nxt = {`NUM_FLAGS{1'b0}};
      if (AVS_READ_I) begin
        // writes leave the last read word standing
        rdata_nxt = 32'h00000000;
        if (is_reg(AVS_ADDRESS_I, `ADDR_FLAGS)) begin
          rdata_nxt = flags_word(flag, rt_state);
          snap_nxt = flag;
        end else if (is_reg(AVS_ADDRESS_I, `ADDR_ISTAT)) begin
          rdata_nxt[`NUM_FLAGS-1:0] = istat_r;
          snap_nxt = istat_r;
        end else if (is_reg(AVS_ADDRESS_I, `ADDR_IMASK)) begin
          rdata_nxt[`NUM_FLAGS-1:0] = imask_r;
        end
      end else if (is_reg(AVS_ADDRESS_I, `ADDR_CMD)) begin
        if (AVS_WRITEDATA_I == `CMD_FLAG_READ) begin
          snap_nxt = flag;
        end
      end
    end else if (done) begin
      // side effects land at the completing edge
      if (AVS_READ_I && is_reg(AVS_ADDRESS_I, `ADDR_FLAGS)) begin
        fclr_go = 1'b1;
      end
      if (AVS_READ_I && is_reg(AVS_ADDRESS_I, `ADDR_ISTAT)) begin
        iclr = snap_r;
      end
      if (AVS_WRITE_I && is_reg(AVS_ADDRESS_I, `ADDR_CMD)) begin
        // command form of the flag read
        fclr_go = 1'b1;
      end
      if (AVS_WRITE_I && is_reg(AVS_ADDRESS_I, `ADDR_IMASK)) begin
        if (AVS_BYTEENABLE_I[0]) begin
          imask_nxt[7:0] = AVS_WRITEDATA_I[7:0];
        end
        if (AVS_BYTEENABLE_I[1]) begin
          imask_nxt[`NUM_FLAGS-1:8] = AVS_WRITEDATA_I[`NUM_FLAGS-1:8];
        end
      end
    end
  end

  // new fault events beat a clearing read
  // irq from the next status so it rises with the flag
  always @* begin
    istat_nxt = (istat_r & ~iclr) | rise;
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  // one fixed wait cycle keeps every answer on the same edge
  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wait_r <= 1'b1;
    end else if (CE_I) begin
      wait_r <= wait_nxt;
    end
  end

  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_r <= 32'h00000000;
    end else if (CE_I) begin
      rdata_r <= rdata_nxt;
    end
  end

  // snapshot limits a clear to bits the host has seen
  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      snap_r <= {`NUM_FLAGS{1'b0}};
    end else if (CE_I) begin
      snap_r <= snap_nxt;
    end
  end

  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      istat_r <= {`NUM_FLAGS{1'b0}};
    end else if (CE_I) begin
      istat_r <= istat_nxt;
    end
  end

  // bytes 2 and 3 of the mask word hold nothing
  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      imask_r <= `IMASK_RESET;
    end else if (CE_I) begin
      imask_r <= imask_nxt;
    end
  end

  always @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_r <= 1'b0;
    end else if (CE_I) begin
      irq_r <= irq_nxt;
    end
  end

  assign AVS_READDATA_O = rdata_r;
  assign AVS_WAITREQUEST_O = wait_r;
  assign IRQ_O = irq_r;
endmodule
`default_nettype wire

// ### tb/can_diag_checker.sv
// Purpose: bus and flag checks on the block ports
// Assumes: one clock, async reset
// Notes: bound at foot of file
`timescale 1ns/1ps
`default_nettype none
module can_diag_checker (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic OVERTEMP_I,
  input wire logic DRV_EN_I,
  input wire logic RCV_EN_I,
  input wire logic WAKE_RCV_EN_I
);
  wire logic [2:0] rt = {WAKE_RCV_EN_I, RCV_EN_I, DRV_EN_I};
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  sequence taken;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CE_I;
  endsequence
  sequence flags_read;
    taken ##0 (AVS_READ_I && AVS_ADDRESS_I[3:2] == 2'h0);
  endsequence
  chk_answer_next: assert property (taken |=> !AVS_WAITREQUEST_O)
    else $error("no answer after request");
  chk_wait_pulse: assert property (!AVS_WAITREQUEST_O && CE_I
    |=> AVS_WAITREQUEST_O) else $error("wait low too long");
  chk_no_spurious: assert property (AVS_WAITREQUEST_O && !AVS_READ_I
    && !AVS_WRITE_I |=> AVS_WAITREQUEST_O) else $error("answer unasked");
  chk_unused_zero: assert property (AVS_READDATA_O[31:19] == 13'h0
    && AVS_READDATA_O[15:14] == 2'h0) else $error("unused bits set");
  chk_data_hold: assert property (AVS_WAITREQUEST_O
    && $past(AVS_WAITREQUEST_O) |-> $stable(AVS_READDATA_O))
    else $error("read data moved");
  chk_write_hold: assert property (taken ##0 AVS_WRITE_I
    |=> $stable(AVS_READDATA_O)) else $error("write moved data");
  chk_ce_freeze: assert property (!CE_I |=> $stable(AVS_WAITREQUEST_O)
    && $stable(AVS_READDATA_O)) else $error("moved while frozen");
  chk_rt_live: assert property (($stable(rt) && CE_I)[*4] ##0 flags_read
    |=> AVS_READDATA_O[18:16] == $past(rt)) else $error("state bits");
  chk_fault_seen: assert property ((OVERTEMP_I && CE_I)[*5]
    ##0 flags_read |=> AVS_READDATA_O[0]) else $error("fault not seen");
endmodule
bind can_diag_flags can_diag_checker chk_u (.*);
`default_nettype wire

// ### tb/can_host_model.sv
// Purpose: host side bus master
// Assumes: called just after a rising edge
// Notes: bounded wait, counts timeouts
`timescale 1ns/1ps
`default_nettype none
module can_host_model (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i,
  output logic [3:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o
);
  int tmo = 0;
  initial begin
    {addr_o, rd_o, wr_o, wdata_o} = '0;
  end
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr_o <= a;
    wdata_o <= d;
    rd_o <= !w;
    wr_o <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_i !== 1'b0 && n < 99);
    q = rdata_i;
    tmo += (wait_i !== 1'b0);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_can_diag_flags.sv
// Purpose: self-checking bench for can_diag_flags
// Assumes: 25 MHz clock
// Notes: flt[4] is the raw bus level
`timescale 1ns/1ps
`default_nettype none
`include "can_diag_defs.vh"
module tb_can_diag_flags;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [13:0] flt = 14'h0;
  logic [2:0] rt = 3'h5;
  logic [3:0] addr;
  logic rd, wr, wt, irq;
  logic [31:0] wd, rdat, q;
  int bad_count = 0;
  int compares = 0;
  always #20 clk = ~clk;
  can_host_model host (.clk_i(clk), .rdata_i(rdat), .wait_i(wt),
    .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  can_diag_flags dut_u (.MCLK_I(clk), .RESET_I(rst), .CE_I(ce),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .IRQ_O(irq),
    .OVERTEMP_I(flt[0]), .RX_LOW_I(flt[1]), .RX_HIGH_I(flt[2]),
    .TX_DOM_I(flt[3]), .BUS_DOM_I(flt[4]), .OVERCURRENT_I(flt[5]),
    .BUS_FAIL_PENDING_I(flt[6]), .BUS_FAIL_IDENT_I(flt[7]),
    .CANL_BAT_I(flt[8]), .CANL_VDD_I(flt[9]), .CANL_GND_I(flt[10]),
    .CANH_BAT_I(flt[11]), .CANH_VDD_I(flt[12]), .CANH_GND_I(flt[13]),
    .DRV_EN_I(rt[0]), .RCV_EN_I(rt[1]), .WAKE_RCV_EN_I(rt[2]));
  task automatic conclude();
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic xf(input logic w, input logic [3:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q);
    if (host.tmo != 0) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [31:0] fw(input logic [13:0] f);
    return {13'h0, rt, 2'h0, f};
  endfunction
  // flags read: expect value e
  task automatic rdf(input logic [13:0] e);
    xf(1'b0, 4'h0, 32'h0);
    chk("flags", fw(e), q);
  endtask
  task automatic t_reset();
    ce <= 1'b0;
    idle(3);
    ce <= 1'b1;
    // real-time bits need two running edges through the sync
    idle(4);
    rdf(14'h0);
    xf(1'b0, 4'h8, 32'h0);
    chk("mask reset", 32'h0, q);
    xf(1'b1, 4'h0, 32'hffff);
    rdf(14'h0);
  endtask
  task automatic t_latch();
    for (int i = 0; i < 14; i++) begin
      if (i == 4)
        continue;
      flt[i] <= 1'b1;
      idle(4);
      rdf(14'h1 << i);
      rdf(14'h1 << i);
      flt[i] <= 1'b0;
      idle(4);
      rdf(14'h1 << i);
      rdf(14'h0);
    end
  endtask
  // dominant just short of the timeout must not latch
  task automatic t_clamp();
    flt[4] <= 1'b1;
    idle(`DOM_TIMEOUT_CYC - 8);
    rdf(14'h0);
    idle(20);
    rdf(14'h10);
    flt[4] <= 1'b0;
    idle(4);
    rdf(14'h10);
    rdf(14'h0);
  endtask
  task automatic t_cmd();
    rt <= 3'h2;
    for (int j = 0; j < 2; j++) begin
      flt[10] <= 1'b1;
      idle(4);
      flt[10] <= 1'b0;
      idle(4);
      xf(1'b1, 4'hc, j ? 32'h2180 : 32'h2100);
      rdf(j ? 14'h0 : 14'h400);
    end
  endtask
  task automatic t_irq();
    xf(1'b0, 4'h4, 32'h0);
    chk("events", 32'h3fff, q);
    xf(1'b1, 4'h8, 32'h1);
    flt[0] <= 1'b1;
    flt[5] <= 1'b1;
    idle(4);
    chk("irq on", 32'h1, {31'h0, irq});
    xf(1'b0, 4'h4, 32'h0);
    chk("events", 32'h21, q);
    chk("irq off", 32'h0, {31'h0, irq});
    flt <= 14'h0;
    idle(4);
    rdf(14'h21);
    rdf(14'h0);
  endtask
  initial begin
    idle(16);
    rst <= 1'b0;
    idle(1);
    t_reset();
    t_latch();
    t_clamp();
    t_cmd();
    t_irq();
    conclude();
  end
  // hang guard
  initial begin
    idle(20000);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
